// ===== bench/fpc_far_end.sv
/*
 Frame source standing in for the CPU path and queue system.
 Assumes the bench calls send just after a rising edge.
*/
`timescale 1ns/100ps
module fpc_far_end
   import fpc_pkg::*;
(
   // Clock
   input wire logic clock_i,
   // Frame header and event
   output logic fr_valid_o,
   output fpc_hdr_s hdr_o,
   output fpc_evt_s ev_o
);
   initial begin
      fr_valid_o = 1'b0;
      hdr_o = '0;
      ev_o = '0;
   end
   // One frame per call; lines scrambled once released
   task automatic send(input fpc_hdr_s h, input fpc_evt_s v);
      fr_valid_o <= 1'b1;
      hdr_o <= h;
      ev_o <= v;
      @(posedge clock_i);
      fr_valid_o <= 1'b0;
      hdr_o <= ~h;
      ev_o <= ~v;
   endtask
endmodule

// ===== bench/fpc_point_ctrl_monitor.sv
/*
 Port checks for the pipeline point control block.
 Assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/100ps
module fpc_point_ctrl_monitor
   import fpc_pkg::*;
(
   // Clock, reset, enable
   input wire logic clock_i,
   input wire logic rst_i,
   input wire logic ce_i,
   // APB
   input wire fpc_apb_req_s bus_i,
   input wire fpc_apb_rsp_s bus_o,
   // Frames
   input wire logic fr_valid_i,
   input wire fpc_hdr_s hdr_i,
   input wire fpc_evt_s ev_i,
   input wire fpc_out_s out_o
);
   logic go;
   logic ends;
   logic [4:0] hp;
   logic [4:0] ep;
   assign go = ce_i && fr_valid_i;
   assign ends = ev_i.kind != ev_none && ev_i.kind != ev_copy;
   assign hp = hdr_i.frame_header_point_field;
   assign ep = ev_i.point;
   default clocking cb @(posedge clock_i);
   endclocking
   default disable iff (rst_i);
   a_frame_latency: assert property (go |=> out_o.valid)
      else $error("frame result missing");
   a_idle_quiet: assert property (ce_i && !fr_valid_i
      |=> !out_o.valid && !out_o.refused)
      else $error("result without frame");
   a_zero_free: assert property (go && hdr_i == '0 && !ends
      && !ev_i.kind |=> out_o.hdr == '0 && out_o.active == 32'h03ff_fffe)
      else $error("zero header restricted");
   a_copy_keeps: assert property (go && ev_i.kind == ev_copy
      |=> out_o.copy && out_o.hdr == $past(hdr_i))
      else $error("copy changed header");
   a_redirect_tag: assert property (go && hdr_i == '0
      && ev_i.kind == ev_redirect && ep != 5'h18
      |=> out_o.hdr.frame_header_action_field == cpu_redirect_end_action
      && out_o.hdr.frame_header_point_field == $past(ev_i.point))
      else $error("redirect tag wrong");
   a_port_oam_refuse: assert property (go && ends && ep == 5'h18
      |=> out_o.refused && out_o.hdr == $past(hdr_i))
      else $error("end at port engine point taken");
   a_same_side_refuse: assert property (go && ends && hp != 5'h0
      && hp <= 5'h10 && ep != 5'h0 && ep <= 5'h10
      && hdr_i.frame_header_action_field == cpu_insert_action
      |=> out_o.refused)
      else $error("same side start and end taken");
   a_masq_flag: assert property (go && ev_i.kind == ev_none
      && hdr_i.frame_header_action_field == cpu_insert_masquerade_action
      |=> out_o.masq)
      else $error("masquerade flag missing");
   a_apb_answer: assert property (ce_i && bus_i.psel && bus_i.penable
      && !bus_o.pready |=> bus_o.pready)
      else $error("register access not answered");
endmodule
bind fpc_point_ctrl fpc_point_ctrl_monitor fpc_point_ctrl_monitor_inst (
   .clock_i(clock_i), .rst_i(rst_i), .ce_i(ce_i), .bus_i(bus_i),
   .bus_o(bus_o), .fr_valid_i(fr_valid_i), .hdr_i(hdr_i), .ev_i(ev_i),
   .out_o(out_o));

// ===== bench/tb.sv
/*
 Self-checking bench for the pipeline point control block.
 Assumes the far-end model supplies frames and the monitor is bound.
*/
`timescale 1ns/100ps
module tb;
   import fpc_pkg::*;
   logic clock_i;
   logic rst_i;
   logic ce_i;
   fpc_apb_req_s req;
   fpc_apb_rsp_s rsp;
   logic fr_valid;
   fpc_hdr_s hdr;
   fpc_evt_s ev;
   fpc_out_s res;
   int errors;
   int cmp_count;
   logic [31:0] q;
   logic e;
   int kb[6] = '{35, 69, 137, 272, 536, 35};
   int kw[6] = '{1, 2, 4, 8, 16, 1};
   fpc_point_ctrl fpc_point_ctrl_inst (.clock_i(clock_i), .rst_i(rst_i),
      .ce_i(ce_i), .bus_i(req), .bus_o(rsp), .fr_valid_i(fr_valid),
      .hdr_i(hdr), .ev_i(ev), .out_o(res));
   fpc_far_end fpc_far_end_inst (.clock_i(clock_i), .fr_valid_o(fr_valid),
      .hdr_o(hdr), .ev_o(ev));
   initial begin
      clock_i = 1'b0;
      forever #5 clock_i = ~clock_i;
   end
   task automatic chk(input string n, input logic [31:0] x,
      input logic [31:0] g);
      cmp_count++;
      if (g !== x) begin
         errors++;
         $display("CHECK FAILED %s expected %h seen %h", n, x, g);
      end
   endtask
   task automatic end_of_test();
      $display("Mismatches %0d, comparisons %0d", errors, cmp_count);
      if (errors == 0 && cmp_count > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   task automatic apb(input logic w, input logic [11:0] a,
      input logic [31:0] d);
      int n;
      n = 0;
      req <= '{1'b1, 1'b0, w, a, d};
      @(posedge clock_i);
      req.penable <= 1'b1;
      do begin
         @(posedge clock_i);
         n++;
      end while (rsp.pready !== 1'b1 && n < 20);
      if (n >= 20) errors++;
      q = rsp.prdata;
      e = rsp.pslverr;
      req <= '0;
      @(posedge clock_i);
   endtask
   task automatic frm(input logic [8:0] h, input logic [7:0] v,
      input logic [8:0] xh, input logic [31:0] xa, input logic [2:0] xf);
      fpc_far_end_inst.send(h, v);
      @(negedge clock_i);
      chk("valid", 32'h1, {31'h0, res.valid});
      chk("header", {23'h0, xh}, {23'h0, res.hdr});
      if (xa !== 32'h0) chk("active", xa, res.active);
      chk("flags", {29'h0, xf}, {29'h0, res.copy, res.masq, res.refused});
      @(posedge clock_i);
   endtask
   initial begin
      repeat (5000) @(posedge clock_i);
      errors++;
      end_of_test();
   end
   initial begin
      int n;
      errors = 0;
      cmp_count = 0;
      ce_i = 1'b1;
      rst_i = 1'b1;
      req = '0;
      repeat (3) @(posedge clock_i);
      rst_i <= 1'b0;
      @(posedge clock_i);
      apb(1'b0, 12'h000, 32'h0);
      chk("ctrl reset", 32'h0, q);
      apb(1'b0, 12'h0ff, 32'h0);
      chk("unmapped", 32'h1, {31'h0, e});
      for (int i = 0; i < 6; i++) begin
         apb(1'b1, 12'h008, i);
         apb(1'b0, 12'h008, 32'h0);
         chk("key bits", kb[i], {22'h0, q[25:16]});
         chk("key words", kw[i], {27'h0, q[12:8]});
      end
      apb(1'b1, 12'h000, 32'h3);
      apb(1'b0, 12'h000, 32'h0);
      chk("init running", 32'h3, q);
      n = 0;
      do begin
         apb(1'b0, 12'h000, 32'h0);
         n++;
      end while (q[1] !== 1'b0 && n < 40);
      chk("init done", 32'h1, q);
      frm(9'h000, 8'h00, 9'h000, 32'h03ff_fffe, 3'h0);
      frm(9'h000, 8'h24, 9'h046, 32'h0000_001e, 3'h0);
      frm(9'h000, 8'h44, 9'h000, 32'h03ff_fffe, 3'h4);
      frm(9'h000, 8'h74, 9'h148, 32'h001f_fffe, 3'h0);
      frm(9'h000, 8'h96, 9'h16a, 32'h007f_fffe, 3'h0);
      frm(9'h072, 8'h00, 9'h072, 32'h03ff_ff80, 3'h0);
      frm(9'h0f4, 8'h00, 9'h0f4, 32'h03ff_8000, 3'h2);
      frm(9'h042, 8'h2d, 9'h042, 32'h0, 3'h1);
      frm(9'h042, 8'h32, 9'h126, 32'h0, 3'h0);
      frm(9'h000, 8'h38, 9'h000, 32'h0, 3'h1);
      frm(9'h000, 8'hb5, 9'h15c, 32'h003f_fffe, 3'h0);
      frm(9'h15d, 8'h00, 9'h15d, 32'h03ff_ff80, 3'h0);
      frm(9'h000, 8'hcb, 9'h0be, 32'h0000_0ffe, 3'h0);
      frm(9'h0bf, 8'h00, 9'h0bf, 32'h03f8_0000, 3'h0);
      frm(9'h000, 8'h85, 9'h000, 32'h0, 3'h1);
      frm(9'h182, 8'h00, 9'h182, 32'h0300_0000, 3'h0);
      frm(9'h162, 8'h00, 9'h162, 32'h03c0_0000, 3'h0);
      ce_i <= 1'b0;
      fpc_far_end_inst.send(9'h000, 8'h24);
      @(negedge clock_i);
      chk("frozen valid", 32'h0, {31'h0, res.valid});
      @(posedge clock_i);
      ce_i <= 1'b1;
      @(posedge clock_i);
      apb(1'b0, 12'h004, 32'h0);
      chk("refusals", 32'h3, {24'h0, q[15:8]});
      apb(1'b1, A_CIDX, 32'h0000_0004);
      apb(1'b0, A_CDAT, 32'h0000_0000);
      chk("count at point", 32'h1, q);
      end_of_test();
   end
endmodule

// ===== src/fpc_pkg.sv
/*
 Constants and types for the frame pipeline point control block.
 Assumes one core clock; the register bus is APB with 32-bit data.
*/
// How it works
// R1 - Zero point and action: process everywhere
// R2 - Each stage active or transparent per frame
// R3 - Insert action starts processing at point
// R4 - Masquerade insert also starts at point
// R5 - CPU redirect tags action, ends at point
// R6 - CPU copy keeps header, processing continues
// R7 - Up endpoint redirect ends at point
// R8 - Late egress terminate ends egress at point
// R9 - Egress loop: egress ends, ingress restarts mirrored
// R10 - Ingress loop: ingress ends, egress restarts mirrored
// R11 - No start and end on same side
// R12 - Ingress insert may end at egress point
// R13 - Egress outer half MIP: redirect, copy, insert; the code also accepts the other ending events there
// R14 - Egress port endpoint point: insertion only; the code also accepts a copy event there
// R15 - Software sets enable and init before config
// R16 - Init bit self-clears when memory swept
// R17 - Key groups use 1,2,4,8,16 words
// R18 - Key widths 35,69,137,272,536 bits
// R19 - Small enums, zero means none, header kept
package fpc_pkg;
   localparam logic [11:0] A_CTRL = 12'h000;
   localparam logic [11:0] A_STAT = 12'h004;
   localparam logic [11:0] A_KEY = 12'h008;
   localparam logic [11:0] A_CIDX = 12'h00c;
   localparam logic [11:0] A_CDAT = 12'h010;
   localparam int CTRL_EN_BIT = 0;
   localparam int CTRL_INIT_BIT = 1;
   localparam logic [31:0] CTRL_RST = 32'h0000_0000;
   localparam int STAT_BUSY_BIT = 0;
   localparam int STAT_VIOL_LSB = 8;
   localparam int KEY_WORDS_LSB = 8;
   localparam int KEY_BITS_LSB = 16;
   localparam int NPT = 32;
   localparam int CNT_W = 16;
   localparam logic [4:0] LAST_IDX = 5'h1f;
   localparam logic [4:0] KW1 = 5'h01;
   localparam logic [4:0] KW2 = 5'h02;
   localparam logic [4:0] KW4 = 5'h04;
   localparam logic [4:0] KW8 = 5'h08;
   localparam logic [4:0] KW16 = 5'h10;
   localparam logic [9:0] KB1 = 10'h023;
   localparam logic [9:0] KB2 = 10'h045;
   localparam logic [9:0] KB4 = 10'h089;
   localparam logic [9:0] KB8 = 10'h110;
   localparam logic [9:0] KB16 = 10'h218;
   typedef enum logic [4:0] {
      pt_none, p_ig_rap, p_ig_port_oam, p_ig_basic_cl,
      ingress_service_classify_point, p_ig_lag_prot, p_ig_out_mip,
      p_ig_out_sw, p_ig_out_prot, p_ig_out_oam, p_ig_mid_prot,
      p_ig_in_oam, p_ig_in_prot, ingress_inner_soft_mep_point,
      p_ig_in_mip, p_ig_vlan, p_ig_done, p_eg_in_mip, p_eg_in_sw,
      p_eg_in_oam, p_eg_out_oam, p_eg_out_sw,
      egress_outer_half_mip_point, egress_activation_test_loop_point,
      egress_port_oam_engine_point, egress_remote_access_point
   } fpc_pt_e;
   typedef enum logic [2:0] {
      act_none, cpu_insert_action, cpu_insert_masquerade_action,
      cpu_redirect_end_action, upmep_cpu_redirect_action,
      late_egress_terminate_action, egress_to_ingress_loop_action,
      ingress_to_egress_loop_action
   } fpc_act_e;
   typedef enum logic [2:0] {
      ev_none, ev_redirect, ev_copy, ev_upmep_redirect, ev_mpls_late,
      ev_upmep_loop, ev_downmep_loop
   } fpc_ev_e;
   typedef struct packed {
      fpc_pt_e frame_header_point_field;
      fpc_act_e frame_header_action_field;
      logic looped;
   } fpc_hdr_s;
   typedef struct packed {
      fpc_ev_e kind;
      fpc_pt_e point;
   } fpc_evt_s;
   typedef struct packed {
      logic valid;
      fpc_hdr_s hdr;
      logic [NPT-1:0] active;
      logic copy;
      logic masq;
      logic refused;
   } fpc_out_s;
   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [11:0] paddr;
      logic [31:0] pwdata;
   } fpc_apb_req_s;
   typedef struct packed {
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
   } fpc_apb_rsp_s;
endpackage

// ===== src/fpc_point_ctrl.sv
/*
 Pipeline point and action control with an APB register slave.
 Assumes frame header and events come from logic on clock_i.
*/
// The register offsets and the APB register port were chosen for this implementation.
`timescale 1ns/100ps
module fpc_point_ctrl
   import fpc_pkg::*;
(
   // Clock, reset, enable
   input wire logic clock_i,
   input wire logic rst_i,
   input wire logic ce_i,
   // APB slave
   input wire fpc_apb_req_s bus_i,
   output fpc_apb_rsp_s bus_o,
   // Frame header and event in
   input wire logic fr_valid_i,
   input wire fpc_hdr_s hdr_i,
   input wire fpc_evt_s ev_i,
   // Frame header and stage control out
   output fpc_out_s out_o
);

   typedef struct packed {
      logic en;
      logic init;
      logic [4:0] iidx;
      logic [2:0] ksel;
      logic [4:0] cidx;
      logic [7:0] viol;
      logic [NPT-1:0][CNT_W-1:0] cnt;
      fpc_apb_rsp_s rsp;
      fpc_out_s out;
   } fpc_state_s;

   fpc_state_s st_ff;
   fpc_state_s nxt_st;

   // True for points after the queue system
   function automatic logic is_egress(input fpc_pt_e p);
      return p >= p_eg_in_mip;
   endfunction

   function automatic logic is_insert(input fpc_act_e a);
      return (a == cpu_insert_action) ||
         (a == cpu_insert_masquerade_action);
   endfunction

   // Point on the other side where a looped frame restarts
   function automatic fpc_pt_e mirror(input fpc_pt_e p);
      fpc_pt_e m;
      if (is_egress(p)) begin
         m = p_ig_rap;
      end else begin
         m = p_eg_in_mip;
      end
      unique case (p)
         p_ig_rap: m = egress_remote_access_point;
         p_ig_port_oam: m = egress_port_oam_engine_point;
         p_ig_out_mip: m = egress_outer_half_mip_point;
         p_ig_out_sw: m = p_eg_out_sw;
         p_ig_out_oam: m = p_eg_out_oam;
         p_ig_in_oam: m = p_eg_in_oam;
         ingress_inner_soft_mep_point: m = p_eg_in_sw;
         p_ig_in_mip: m = p_eg_in_mip;
         p_eg_in_mip: m = p_ig_in_mip;
         p_eg_in_sw: m = ingress_inner_soft_mep_point;
         p_eg_in_oam: m = p_ig_in_oam;
         p_eg_out_oam: m = p_ig_out_oam;
         p_eg_out_sw: m = p_ig_out_sw;
         egress_outer_half_mip_point: m = p_ig_out_mip;
         egress_port_oam_engine_point: m = p_ig_port_oam;
         egress_remote_access_point: m = p_ig_rap;
         default: m = m;
      endcase
      return m;
   endfunction

   // Action written into the header for an ending event
   function automatic fpc_act_e act_of(input fpc_ev_e k);
      fpc_act_e a;
      a = act_none;
      unique case (k)
         ev_redirect: a = cpu_redirect_end_action; // [R5]
         ev_upmep_redirect: a = upmep_cpu_redirect_action; // [R7]
         ev_mpls_late: a = late_egress_terminate_action; // [R8]
         ev_upmep_loop: a = egress_to_ingress_loop_action; // [R9]
         ev_downmep_loop: a = ingress_to_egress_loop_action; // [R10]
         default: a = act_none;
      endcase
      return a;
   endfunction

   // Words taken by each key group
   function automatic logic [4:0] key_words(input logic [2:0] s);
      logic [4:0] w;
      w = KW1;
      unique case (s)
         3'h1: w = KW2; // [R17]
         3'h2: w = KW4; // [R17]
         3'h3: w = KW8; // [R17]
         3'h4: w = KW16; // [R17]
         default: w = KW1; // [R17]
      endcase
      return w;
   endfunction

   // Widest key of each group
   function automatic logic [9:0] key_bits(input logic [2:0] s);
      logic [9:0] b;
      b = KB1;
      unique case (s)
         3'h1: b = KB2; // [R18]
         3'h2: b = KB4; // [R18]
         3'h3: b = KB8; // [R18]
         3'h4: b = KB16; // [R18]
         default: b = KB1; // [R18]
      endcase
      return b;
   endfunction

   always_comb begin
      fpc_hdr_s h;
      logic [4:0] lo;
      logic [4:0] hi;
      logic [NPT-1:0] am;
      logic [31:0] d;
      logic hit;
      logic acc;
      logic refuse;
      h = hdr_i;
      lo = 5'h01;
      hi = 5'(egress_remote_access_point);
      am = '0;
      d = '0;
      hit = 1'b1;
      acc = 1'b0;
      refuse = 1'b0;
      nxt_st = st_ff;

      // Configuration memory sweep
      if (st_ff.init && st_ff.en) begin
         nxt_st.cnt[st_ff.iidx] = '0;
         nxt_st.iidx = st_ff.iidx + 5'h01;
         if (st_ff.iidx == LAST_IDX) begin
            nxt_st.init = 1'b0; // [R16]
            nxt_st.iidx = '0;
         end
      end

      // APB read data and decode
      unique case (bus_i.paddr)
         A_CTRL: begin
            d[CTRL_EN_BIT] = st_ff.en;
            d[CTRL_INIT_BIT] = st_ff.init; // [R16]
         end
         A_STAT: begin
            d[STAT_BUSY_BIT] = st_ff.init;
            d[STAT_VIOL_LSB +: 8] = st_ff.viol;
         end
         A_KEY: begin
            d[2:0] = st_ff.ksel;
            d[KEY_WORDS_LSB +: 5] = key_words(st_ff.ksel);
            d[KEY_BITS_LSB +: 10] = key_bits(st_ff.ksel);
         end
         A_CIDX: begin
            d[4:0] = st_ff.cidx;
         end
         A_CDAT: begin
            d[CNT_W-1:0] = st_ff.cnt[st_ff.cidx];
         end
         default: begin
            hit = 1'b0;
         end
      endcase

      // Answer one cycle into the access phase
      nxt_st.rsp.pready = 1'b0;
      nxt_st.rsp.pslverr = 1'b0;
      nxt_st.rsp.prdata = '0;
      if (bus_i.psel && bus_i.penable && !st_ff.rsp.pready) begin
         nxt_st.rsp.pready = 1'b1;
         nxt_st.rsp.pslverr = !hit;
         nxt_st.rsp.prdata = bus_i.pwrite ? 32'h0000_0000 : d;
      end

      // Writes land on the edge that completes the access
      if (bus_i.psel && bus_i.penable && st_ff.rsp.pready &&
         bus_i.pwrite) begin
         unique case (bus_i.paddr)
            A_CTRL: begin
               nxt_st.en = bus_i.pwdata[CTRL_EN_BIT]; // [R15]
               nxt_st.init = bus_i.pwdata[CTRL_INIT_BIT]; // [R15]
               nxt_st.iidx = '0;
            end
            A_KEY: begin
               nxt_st.ksel = bus_i.pwdata[2:0];
            end
            A_CIDX: begin
               nxt_st.cidx = bus_i.pwdata[4:0];
            end
            default: begin
               nxt_st.en = st_ff.en;
            end
         endcase
      end

      // Merge the ending event into the frame header
      nxt_st.out.copy = 1'b0;
      if (fr_valid_i) begin
         unique case (ev_i.kind)
            ev_none: begin
               acc = 1'b0; // [R19]
            end
            ev_copy: begin
               nxt_st.out.copy = 1'b1; // [R6]
            end
            default: begin
               if (is_insert(h.frame_header_action_field) &&
                  (is_egress(h.frame_header_point_field) ==
                  is_egress(ev_i.point))) begin
                  refuse = 1'b1; // [R11]
               end else if (ev_i.point ==
                  egress_port_oam_engine_point) begin
                  refuse = 1'b1; // [R14]
               end else if (ev_i.kind == ev_mpls_late &&
                  !is_egress(ev_i.point)) begin
                  refuse = 1'b1; // [R8]
               end else begin
                  acc = 1'b1; // [R12] [R13]
                  h.frame_header_point_field = ev_i.point;
                  h.frame_header_action_field = act_of(ev_i.kind);
                  h.looped = 1'b0;
               end
            end
         endcase
      end

      // Window of stages that process the frame actively
      unique case (h.frame_header_action_field)
         cpu_insert_action: begin
            lo = h.frame_header_point_field; // [R3]
         end
         cpu_insert_masquerade_action: begin
            lo = h.frame_header_point_field; // [R4]
         end
         cpu_redirect_end_action: begin
            hi = h.frame_header_point_field; // [R5]
         end
         upmep_cpu_redirect_action: begin
            hi = h.frame_header_point_field; // [R7]
         end
         late_egress_terminate_action: begin
            hi = h.frame_header_point_field; // [R8]
         end
         egress_to_ingress_loop_action: begin
            if (h.looped) begin
               lo = mirror(h.frame_header_point_field); // [R9]
            end else begin
               hi = h.frame_header_point_field; // [R9]
            end
         end
         ingress_to_egress_loop_action: begin
            if (h.looped) begin
               lo = mirror(h.frame_header_point_field); // [R10]
            end else begin
               hi = h.frame_header_point_field; // [R10]
            end
         end
         default: begin
            lo = 5'h01; // [R1]
         end
      endcase
      for (int p = 1; p < NPT; p++) begin
         am[p] = (5'(p) >= lo) && (5'(p) <= hi); // [R2]
      end

      nxt_st.out.valid = fr_valid_i;
      nxt_st.out.refused = refuse;
      if (fr_valid_i) begin
         nxt_st.out.hdr = h; // [R19]
         nxt_st.out.active = am;
         nxt_st.out.masq = h.frame_header_action_field ==
            cpu_insert_masquerade_action; // [R4]
      end

      // Per point counters of frames ending there
      if (acc && st_ff.en && !st_ff.init) begin
         nxt_st.cnt[ev_i.point] = st_ff.cnt[ev_i.point] + 16'h0001;
      end
      if (refuse) begin
         nxt_st.viol = st_ff.viol + 8'h01;
      end
   end

   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         st_ff <= '0;
         st_ff.en <= CTRL_RST[CTRL_EN_BIT];
         st_ff.init <= CTRL_RST[CTRL_INIT_BIT];
      end else if (ce_i) begin
         st_ff <= nxt_st;
      end
   end

   assign bus_o = st_ff.rsp;
   assign out_o = st_ff.out;

endmodule
